// ---- gtpc_cap_if.sv ----
`timescale 1ns/1ps
`include "gtpc_defines.svh"
interface gtpc_cap_if;
	import gtpc_pkg::*;
	gtpc_word_t                 timebase;
	logic [`GTPC_NCAP-1:0]      level;
	gtpc_edge_e                 edge_sel [`GTPC_NCAP];
	logic [`GTPC_NCAP-1:0]      event_hit;
	gtpc_word_t                 value [`GTPC_NCAP];
	modport main (output timebase, level, edge_sel, input event_hit, value);
	modport capt (input timebase, level, edge_sel, output event_hit, value);
endinterface

// ---- gtpc_capture.sv ----
`timescale 1ns/1ps
`include "gtpc_defines.svh"
module gtpc_capture
	import gtpc_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	gtpc_cap_if.capt  cap
);
	// ==========================================
	// Edge detection and latches
	logic [`GTPC_NCAP-1:0] prev_reg;
	logic [`GTPC_NCAP-1:0] rise;
	logic [`GTPC_NCAP-1:0] fall;
	logic [`GTPC_NCAP-1:0] hit;
	gtpc_word_t            latch_reg [`GTPC_NCAP];

	assign rise = cap.level & ~prev_reg;
	assign fall = ~cap.level & prev_reg;

	always_comb begin
		for (int i = 0; i < `GTPC_NCAP; i++) begin
			unique case (cap.edge_sel[i])
				GTPC_EDGE_OFF:  hit[i] = 1'b0;
				GTPC_EDGE_RISE: hit[i] = rise[i];
				GTPC_EDGE_FALL: hit[i] = fall[i];
				GTPC_EDGE_BOTH: hit[i] = rise[i] | fall[i];
			endcase
		end
	end

	assign cap.event_hit = hit;
	assign cap.value     = latch_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev_reg <= '0;
			for (int i = 0; i < `GTPC_NCAP; i++) begin
				latch_reg[i] <= `GTPC_ZERO16;
			end
		end else begin
			prev_reg <= cap.level;
			for (int i = 0; i < `GTPC_NCAP; i++) begin
				if (hit[i]) begin
					latch_reg[i] <= cap.timebase;
				end
			end
		end
	end
endmodule

// ---- gtpc_defines.svh ----
`ifndef GTPC_DEFINES_SVH
`define GTPC_DEFINES_SVH

// ==========================================
// Register word indices
`define GTPC_IDX_DIR    4'h0
`define GTPC_IDX_DATA   4'h1
`define GTPC_IDX_EDGE   4'h2
`define GTPC_IDX_MASK   4'h3
`define GTPC_IDX_FLAG   4'h4
`define GTPC_IDX_ACCUM  4'h5
`define GTPC_IDX_FPWM   4'h6
`define GTPC_IDX_TBASE  4'h7
`define GTPC_IDX_PRESC  4'h8
`define GTPC_IDX_CAP0   4'h9
`define GTPC_IDX_CAPN   4'hC

// ==========================================
// Field positions
`define GTPC_M2_OVF_EN   7
`define GTPC_M2_CC_OUT   5
`define GTPC_FL_OVF      7
`define GTPC_HI_BYTE     8
`define GTPC_AC_ACC_IN   7
`define GTPC_AC_AUX      6
`define GTPC_AC_CAP4     2
`define GTPC_FP_LVL_A    9
`define GTPC_FP_LVL_B    8
`define GTPC_PC_HI_A     5
`define GTPC_PC_HI_B     4
`define GTPC_PC_PWM_OUT  3
`define GTPC_PIN_CMP1    4
`define GTPC_PIN_OC5     3
`define GTPC_PIN_OCBASE  4

// ==========================================
// Widths and constants
`define GTPC_NPIN        8
`define GTPC_NCAP        4
`define GTPC_NOC         5
`define GTPC_NFILT       6
`define GTPC_FILT_AUX    4
`define GTPC_FILT_ACC    5
`define GTPC_PRE_W       9
`define GTPC_SEL_W       3
`define GTPC_SEL_AUX     3'h7
`define GTPC_CC_TAP0     4'h1
`define GTPC_PWM_TAP0    4'h0
`define GTPC_TAP_512     4'h8
`define GTPC_CNT_MAX     16'hFFFF
`define GTPC_ZERO16      16'h0000
`define GTPC_ZERO8       8'h00

`endif

// ---- gtpc_far_model.sv ----
`timescale 1ns/1ps
module gtpc_far_model (
	input wire logic       clk,
	input wire logic [7:0] ext_level,
	input wire logic       aux_run,
	input wire logic       aux_rest,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	output logic     [7:0] pin_in,
	output logic           aux_clk
);
	localparam int AUX_HALF = 5;
	int   cnt = 0;
	logic ph  = 1'b0;
	// ==========================================
	// Pin resolution and auxiliary clock
	assign pin_in  = (pin_oe & pin_out) | (~pin_oe & ext_level);
	assign aux_clk = aux_run ? ph : aux_rest;
	always @(negedge clk) begin
		if (!aux_run) begin
			cnt = 0;
			ph  = 1'b0;
		end else if (cnt == AUX_HALF - 1) begin
			cnt = 0;
			ph  = ~ph;
		end else begin
			cnt++;
		end
	end
endmodule

// ---- gtpc_pin_filter.sv ----
`timescale 1ns/1ps
`include "gtpc_defines.svh"
module gtpc_pin_filter
	import gtpc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic [`GTPC_NFILT-1:0] raw_in,
	output logic      [`GTPC_NFILT-1:0] filt_out
);
	// ==========================================
	// Two agreeing high samples raise the output; one low sample clears it
	logic [`GTPC_NFILT-1:0] samp_reg;
	logic [`GTPC_NFILT-1:0] filt_next;

	assign filt_next = (samp_reg & raw_in) | (filt_out & ~(samp_reg ^ raw_in));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			samp_reg <= '0;
			filt_out <= '0;
		end else begin
			samp_reg <= raw_in;
			filt_out <= filt_next;
		end
	end
endmodule

// ---- gtpc_pkg.sv ----
package gtpc_pkg;
	typedef enum logic [1:0] {
		GTPC_EDGE_OFF  = 2'h0,
		GTPC_EDGE_RISE = 2'h1,
		GTPC_EDGE_FALL = 2'h2,
		GTPC_EDGE_BOTH = 2'h3
	} gtpc_edge_e;
	typedef logic [15:0] gtpc_word_t;
endpackage

// ---- gtpc_timer.sv ----
`timescale 1ns/1ps
`include "gtpc_defines.svh"
module gtpc_timer
	import gtpc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   test_mode,
	input  wire logic                   freeze_mode,
	input  wire logic [3:0]             reg_addr,
	input  wire logic                   reg_rd,
	input  wire logic                   reg_wr,
	input  wire logic [15:0]            reg_wdata,
	output logic      [15:0]            reg_rdata,
	input  wire logic [`GTPC_NPIN-1:0]  gp_pin_in,
	output logic      [`GTPC_NPIN-1:0]  gp_pin_out,
	output logic      [`GTPC_NPIN-1:0]  gp_pin_oe,
	input  wire logic [`GTPC_NOC-1:0]   oc_active,
	input  wire logic [`GTPC_NOC-1:0]   oc_level,
	input  wire logic                   accum_input_pin,
	input  wire logic                   aux_clk_pin,
	input  wire logic                   pwm_wave_a,
	input  wire logic                   pwm_wave_b,
	output logic                        pwm_out_a,
	output logic                        pwm_out_b,
	output logic                        pwm_clk_tick,
	output logic                        pa_clk_div512,
	output logic                        pa_clk_aux,
	output logic                        pa_clk_cc,
	output logic                        irq_req
);
	// ==========================================
	// Helpers
	function automatic logic tap_tick(input logic [`GTPC_PRE_W-1:0] cnt,
	                                  input logic [3:0] idx);
		logic [`GTPC_PRE_W-1:0] mask;
		mask = `GTPC_PRE_W'((10'h2 << idx) - 10'h1);
		return &(cnt | ~mask);
	endfunction

	function automatic logic sel_tick(input logic [`GTPC_PRE_W-1:0] cnt,
	                                  input logic [`GTPC_SEL_W-1:0] sel,
	                                  input logic [3:0] base,
	                                  input logic aux);
		if (sel == `GTPC_SEL_AUX) begin
			return aux;
		end
		return tap_tick(cnt, base + {1'b0, sel});
	endfunction

	// ==========================================
	// Registers
	logic [`GTPC_PRE_W-1:0]   presc_reg;
	gtpc_word_t               timebase_reg;
	logic [7:0]               port_direction_reg;
	logic [7:0]               port_data_reg;
	logic [7:0]               edge_control_reg;
	logic [7:0]               irq_mask_reg1;
	logic [7:0]               irq_mask_reg2;
	logic [7:0]               flag_reg1;
	logic [7:0]               flag_reg2;
	logic [7:0]               armed1_reg;
	logic [7:0]               armed2_reg;
	logic [7:0]               accum_control_reg;
	logic [7:0]               compare_force_reg;
	logic [7:0]               pwm_control_reg;
	logic                     cc_sel_locked_reg;
	logic                     aux_prev_reg;

	// ==========================================
	// Decode
	logic wr_dir, wr_data, wr_edge, wr_mask, wr_flag, wr_accum, wr_fpwm;
	logic wr_tbase, wr_presc, rd_flag, test_or_frz, cc_sel_ok;

	assign wr_dir      = reg_wr && reg_addr == `GTPC_IDX_DIR;
	assign wr_data     = reg_wr && reg_addr == `GTPC_IDX_DATA;
	assign wr_edge     = reg_wr && reg_addr == `GTPC_IDX_EDGE;
	assign wr_mask     = reg_wr && reg_addr == `GTPC_IDX_MASK;
	assign wr_flag     = reg_wr && reg_addr == `GTPC_IDX_FLAG;
	assign wr_accum    = reg_wr && reg_addr == `GTPC_IDX_ACCUM;
	assign wr_fpwm     = reg_wr && reg_addr == `GTPC_IDX_FPWM;
	assign test_or_frz = test_mode | freeze_mode;
	assign wr_tbase    = reg_wr && reg_addr == `GTPC_IDX_TBASE && test_or_frz;
	assign wr_presc    = reg_wr && reg_addr == `GTPC_IDX_PRESC && freeze_mode;
	assign rd_flag     = reg_rd && reg_addr == `GTPC_IDX_FLAG;
	assign cc_sel_ok   = !cc_sel_locked_reg || test_or_frz;

	// ==========================================
	// Filters and clock selection
	logic [`GTPC_NFILT-1:0] filt;
	logic aux_lvl, acc_lvl, aux_tick, cc_tick, pwm_tick, div512_tick;

	gtpc_pin_filter u_filter (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.raw_in   ({accum_input_pin, aux_clk_pin, gp_pin_in[`GTPC_NCAP-1:0]}),
		.filt_out (filt)
	);

	assign aux_lvl     = filt[`GTPC_FILT_AUX];
	assign acc_lvl     = filt[`GTPC_FILT_ACC];
	assign aux_tick    = aux_lvl & ~aux_prev_reg;
	assign cc_tick     = sel_tick(presc_reg, irq_mask_reg2[`GTPC_SEL_W-1:0],
	                              `GTPC_CC_TAP0, aux_tick);
	assign pwm_tick    = sel_tick(presc_reg, pwm_control_reg[`GTPC_SEL_W-1:0],
	                              `GTPC_PWM_TAP0, aux_tick);
	assign div512_tick = tap_tick(presc_reg, `GTPC_TAP_512);

	// ==========================================
	// Capture channels
	gtpc_cap_if cap ();
	logic [`GTPC_NCAP-1:0] cap_src;
	logic                  cap4_on;

	assign cap4_on      = accum_control_reg[`GTPC_AC_CAP4];
	assign cap.timebase = timebase_reg;
	assign cap_src      = (port_direction_reg[`GTPC_NCAP-1:0] &
	                       port_data_reg[`GTPC_NCAP-1:0]) |
	                      (~port_direction_reg[`GTPC_NCAP-1:0] &
	                       filt[`GTPC_NCAP-1:0]);
	assign cap.level    = cap_src;

	always_comb begin
		for (int i = 0; i < `GTPC_NCAP; i++) begin
			cap.edge_sel[i] = gtpc_edge_e'(edge_control_reg[2*i +: 2]);
		end
		if (!cap4_on) begin
			cap.edge_sel[`GTPC_NCAP-1] = GTPC_EDGE_OFF;
		end
	end

	gtpc_capture u_capture (
		.clk     (clk),
		.sys_rst (sys_rst),
		.cap     (cap)
	);

	// ==========================================
	// Flags
	logic [7:0] set1, set2, flag1_next, flag2_next;
	logic       ovf_hit;

	assign ovf_hit = cc_tick && !wr_tbase && timebase_reg == `GTPC_CNT_MAX;
	assign set1    = {{(8-`GTPC_NCAP){1'b0}}, cap.event_hit};
	assign set2    = {ovf_hit, 7'h00};
	assign flag1_next = set1 | (flag_reg1 & ~(wr_flag ?
	                    armed1_reg & ~reg_wdata[15:8] : `GTPC_ZERO8));
	assign flag2_next = set2 | (flag_reg2 & ~(wr_flag ?
	                    armed2_reg & ~reg_wdata[7:0] : `GTPC_ZERO8));

	// ==========================================
	// Pin outputs
	logic [`GTPC_NPIN-1:0] pin_out_next;
	logic                  pwm_a_next, pwm_b_next;

	always_comb begin
		pin_out_next = port_data_reg;
		for (int i = 0; i < `GTPC_NOC; i++) begin
			if (i == `GTPC_NOC-1) begin
				if (oc_active[i] && !cap4_on) begin
					pin_out_next[`GTPC_PIN_OC5] = oc_level[i];
				end
			end else if (oc_active[i]) begin
				pin_out_next[`GTPC_PIN_OCBASE+i] = oc_level[i];
			end
		end
		if (irq_mask_reg2[`GTPC_M2_CC_OUT]) begin
			pin_out_next[`GTPC_PIN_CMP1] = cc_tick;
		end
	end

	assign pwm_a_next = pwm_control_reg[`GTPC_PC_PWM_OUT] ? pwm_tick :
	                    compare_force_reg[`GTPC_FP_LVL_A-`GTPC_HI_BYTE] ?
	                    pwm_control_reg[`GTPC_PC_HI_A] : pwm_wave_a;
	assign pwm_b_next = compare_force_reg[`GTPC_FP_LVL_B-`GTPC_HI_BYTE] ?
	                    pwm_control_reg[`GTPC_PC_HI_B] : pwm_wave_b;

	// ==========================================
	// Read data
	logic [15:0] rdata_next;

	always_comb begin
		rdata_next = `GTPC_ZERO16;
		if (reg_addr >= `GTPC_IDX_CAP0 && reg_addr <= `GTPC_IDX_CAPN) begin
			rdata_next = cap.value[2'(reg_addr - `GTPC_IDX_CAP0)];
		end else begin
			unique case (reg_addr)
				`GTPC_IDX_DIR:   rdata_next = {8'h00, port_direction_reg};
				`GTPC_IDX_DATA:  rdata_next = {8'h00, gp_pin_in};
				`GTPC_IDX_EDGE:  rdata_next = {8'h00, edge_control_reg};
				`GTPC_IDX_MASK:  rdata_next = {irq_mask_reg1, irq_mask_reg2};
				`GTPC_IDX_FLAG:  rdata_next = {flag_reg1, flag_reg2};
				`GTPC_IDX_ACCUM: begin
					rdata_next = {8'h00, accum_control_reg};
					rdata_next[`GTPC_AC_ACC_IN] = acc_lvl;
					rdata_next[`GTPC_AC_AUX] = aux_lvl;
				end
				`GTPC_IDX_FPWM:  rdata_next = {compare_force_reg, pwm_control_reg};
				`GTPC_IDX_TBASE: rdata_next = timebase_reg;
				`GTPC_IDX_PRESC: rdata_next = {7'h00, presc_reg};
				default:         rdata_next = `GTPC_ZERO16;
			endcase
		end
	end

	// ==========================================
	// Counters
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			presc_reg    <= '0;
			timebase_reg <= `GTPC_ZERO16;
			aux_prev_reg <= 1'b0;
		end else begin
			aux_prev_reg <= aux_lvl;
			presc_reg    <= wr_presc ? reg_wdata[`GTPC_PRE_W-1:0] :
			                presc_reg + `GTPC_PRE_W'(1);
			if (wr_tbase) begin
				timebase_reg <= reg_wdata;
			end else if (cc_tick) begin
				timebase_reg <= timebase_reg + 16'h0001;
			end
		end
	end

	// ==========================================
	// Control registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			port_direction_reg <= `GTPC_ZERO8;
			port_data_reg      <= `GTPC_ZERO8;
			edge_control_reg   <= `GTPC_ZERO8;
			irq_mask_reg1      <= `GTPC_ZERO8;
			irq_mask_reg2      <= `GTPC_ZERO8;
			accum_control_reg  <= `GTPC_ZERO8;
			compare_force_reg  <= `GTPC_ZERO8;
			pwm_control_reg    <= `GTPC_ZERO8;
			cc_sel_locked_reg  <= 1'b0;
		end else begin
			if (wr_dir) begin
				port_direction_reg <= reg_wdata[7:0];
			end
			if (wr_data) begin
				port_data_reg <= reg_wdata[7:0];
			end
			if (wr_edge) begin
				edge_control_reg <= reg_wdata[7:0];
			end
			if (wr_mask) begin
				irq_mask_reg1 <= reg_wdata[15:8];
				irq_mask_reg2[7:`GTPC_SEL_W] <= reg_wdata[7:`GTPC_SEL_W];
				if (cc_sel_ok) begin
					irq_mask_reg2[`GTPC_SEL_W-1:0] <= reg_wdata[`GTPC_SEL_W-1:0];
					cc_sel_locked_reg <= 1'b1;
				end
			end
			if (wr_accum) begin
				accum_control_reg <= reg_wdata[7:0];
			end
			if (wr_fpwm) begin
				compare_force_reg <= {6'h00, reg_wdata[`GTPC_FP_LVL_A:`GTPC_FP_LVL_B]};
				pwm_control_reg   <= reg_wdata[7:0];
			end
		end
	end

	// ==========================================
	// Flag registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flag_reg1  <= `GTPC_ZERO8;
			flag_reg2  <= `GTPC_ZERO8;
			armed1_reg <= `GTPC_ZERO8;
			armed2_reg <= `GTPC_ZERO8;
		end else begin
			flag_reg1 <= flag1_next;
			flag_reg2 <= flag2_next;
			if (rd_flag) begin
				armed1_reg <= flag_reg1 & ~set1;
				armed2_reg <= flag_reg2 & ~set2;
			end else if (wr_flag) begin
				armed1_reg <= `GTPC_ZERO8;
				armed2_reg <= `GTPC_ZERO8;
			end else begin
				armed1_reg <= armed1_reg & ~set1;
				armed2_reg <= armed2_reg & ~set2;
			end
		end
	end

	// ==========================================
	// Output flops
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata     <= `GTPC_ZERO16;
			gp_pin_out    <= `GTPC_ZERO8;
			gp_pin_oe     <= `GTPC_ZERO8;
			pwm_out_a     <= 1'b0;
			pwm_out_b     <= 1'b0;
			pwm_clk_tick  <= 1'b0;
			pa_clk_div512 <= 1'b0;
			pa_clk_aux    <= 1'b0;
			pa_clk_cc     <= 1'b0;
			irq_req       <= 1'b0;
		end else begin
			if (reg_rd) begin
				reg_rdata <= rdata_next;
			end
			gp_pin_out    <= pin_out_next;
			gp_pin_oe     <= port_direction_reg;
			pwm_out_a     <= pwm_a_next;
			pwm_out_b     <= pwm_b_next;
			pwm_clk_tick  <= pwm_tick;
			pa_clk_div512 <= div512_tick;
			pa_clk_aux    <= aux_tick;
			pa_clk_cc     <= cc_tick;
			irq_req       <= |(flag_reg1 & irq_mask_reg1) |
			                 (flag_reg2[`GTPC_FL_OVF] & irq_mask_reg2[`GTPC_M2_OVF_EN]);
		end
	end
endmodule

// ---- gtpc_timer_chk.sv ----
`timescale 1ns/1ps
`include "gtpc_defines.svh"
module gtpc_timer_chk
	import gtpc_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        freeze_mode,
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic [7:0]  gp_pin_out,
	input wire logic [7:0]  gp_pin_oe,
	input wire logic [4:0]  oc_active,
	input wire logic [4:0]  oc_level,
	input wire logic        accum_input_pin,
	input wire logic        aux_clk_pin,
	input wire logic        pwm_clk_tick,
	input wire logic        pa_clk_div512,
	input wire logic        pa_clk_cc,
	input wire logic        irq_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// Divide-by-512 gap counter
	logic [9:0] gap_reg;
	logic       armed_reg;
	wire        presc_wr = reg_wr && reg_addr == 4'h8 && freeze_mode;
	wire        rd_acc   = reg_rd && reg_addr == 4'h5;
	always_ff @(posedge clk) begin
		if (sys_rst || presc_wr) begin
			gap_reg   <= 10'h000;
			armed_reg <= 1'b0;
		end else begin
			gap_reg   <= pa_clk_div512 ? 10'h001 : gap_reg + 10'h001;
			armed_reg <= armed_reg | pa_clk_div512;
		end
	end
	// ==========================================
	// Properties
	sequence s_acc_high;
		accum_input_pin [*6];
	endsequence
	sequence s_aux_low;
		(!aux_clk_pin) [*6];
	endsequence
	property p_reset_quiet;
		$fell(sys_rst) |-> reg_rdata == 16'h0000 && !irq_req;
	endproperty
	property p_div512_gap;
		pa_clk_div512 && armed_reg |-> gap_reg == 10'h200;
	endproperty
	property p_pwm_tick_one;
		pwm_clk_tick |=> !pwm_clk_tick;
	endproperty
	property p_cc_tick_one;
		pa_clk_cc |=> !pa_clk_cc;
	endproperty
	property p_presc_upper;
		reg_rd && reg_addr == 4'h8 |=> reg_rdata[15:9] == 7'h00;
	endproperty
	property p_rdata_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	property p_acc_level;
		s_acc_high ##0 rd_acc |=> reg_rdata[`GTPC_AC_ACC_IN];
	endproperty
	property p_aux_level;
		s_aux_low ##0 rd_acc |=> !reg_rdata[`GTPC_AC_AUX];
	endproperty
	property p_dir_oe;
		reg_wr && reg_addr == 4'h0 |=> ##1 gp_pin_oe == 8'($past(reg_wdata, 2));
	endproperty
	property p_oc_pin;
		oc_active[1] |=> gp_pin_out[5] == $past(oc_level[1]);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not clear after reset");
	a_div512_gap: assert property (p_div512_gap) else $error("div512 period wrong");
	a_pwm_tick_one: assert property (p_pwm_tick_one) else $error("pwm tick too wide");
	a_cc_tick_one: assert property (p_cc_tick_one) else $error("cc tick too wide");
	a_presc_upper: assert property (p_presc_upper) else $error("prescaler upper bits set");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	a_acc_level: assert property (p_acc_level) else $error("accum level bit wrong");
	a_aux_level: assert property (p_aux_level) else $error("aux level bit wrong");
	a_dir_oe: assert property (p_dir_oe) else $error("pin enable not direction");
	a_oc_pin: assert property (p_oc_pin) else $error("compare pin not compare level");
endmodule
bind gtpc_timer gtpc_timer_chk u_chk (.clk(clk), .sys_rst(sys_rst), .freeze_mode(freeze_mode),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
	.oc_active(oc_active), .oc_level(oc_level), .accum_input_pin(accum_input_pin),
	.aux_clk_pin(aux_clk_pin), .pwm_clk_tick(pwm_clk_tick), .pa_clk_div512(pa_clk_div512),
	.pa_clk_cc(pa_clk_cc), .irq_req(irq_req));

// ---- gtpc_timer_tb.sv ----
`timescale 1ns/1ps
module gtpc_timer_tb;
	logic        clk, sys_rst, test_mode, freeze_mode, reg_rd, reg_wr;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d, c1;
	logic [7:0]  pin_in, pin_out, pin_oe, ext_level;
	logic [4:0]  oc_active, oc_level;
	logic        acc_in, aux, aux_run, aux_rest, wave_a, wave_b, out_a, out_b;
	logic        t_pwm, t_512, t_aux, t_cc, irq;
	int          failures = 0;
	int          n_tests  = 0;
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	gtpc_timer DUT (.clk(clk), .sys_rst(sys_rst), .test_mode(test_mode),
		.freeze_mode(freeze_mode), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gp_pin_in(pin_in),
		.gp_pin_out(pin_out), .gp_pin_oe(pin_oe), .oc_active(oc_active),
		.oc_level(oc_level), .accum_input_pin(acc_in), .aux_clk_pin(aux),
		.pwm_wave_a(wave_a), .pwm_wave_b(wave_b), .pwm_out_a(out_a), .pwm_out_b(out_b),
		.pwm_clk_tick(t_pwm), .pa_clk_div512(t_512), .pa_clk_aux(t_aux),
		.pa_clk_cc(t_cc), .irq_req(irq));
	gtpc_far_model u_far (.clk(clk), .ext_level(ext_level), .aux_run(aux_run),
		.aux_rest(aux_rest), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
		.aux_clk(aux));
	// ==========================================
	// Shared tasks
	task close_out;
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		n_tests++;
		if (got >= lo && got <= hi) begin
		end else begin
			failures++;
			$display("CHECK FAILED t=%0t got %h out of %h..%h", $time, got, lo, hi);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] v);
		@(negedge clk);
		reg_addr  = a;
		reg_wdata = v;
		reg_wr    = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [15:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		v      = reg_rdata;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return t_cc;
			1: return t_pwm;
			2: return t_512;
			3: return t_aux;
			4: return pin_out[4];
			default: return out_a;
		endcase
	endfunction
	task per(input int w, input int e);
		int   n, k;
		logic a, b;
		n = 0;
		k = 0;
		b = 1'b1;
		while (k < 2 && n < 3000) begin
			@(negedge clk);
			a = pick(w);
			n++;
			if (a === 1'b1 && b === 1'b0) begin
				k++;
				if (k == 1)
					n = 0;
			end
			b = a;
		end
		if (k < 2) begin
			failures++;
			$display("CHECK FAILED t=%0t no period seen", $time);
			close_out;
		end
		chk(16'(n), 16'(e));
	endtask
	task wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (irq !== 1'b1) begin
			failures++;
			$display("CHECK FAILED t=%0t no interrupt request", $time);
			close_out;
		end
	endtask
	// ==========================================
	// Scenarios
	task t_reset;
		rd(4'h2, d);
		chk(d, 16'h0000);
		rd(4'h4, d);
		chk(d, 16'h0000);
		rd(4'h7, d);
		rng(d, 16'h0000, 16'h0010);
		per(0, 4);
		per(1, 2);
	endtask
	task t_presc;
		per(2, 512);
		for (int n = 0; n < 7; n++) begin
			wr(4'h6, 16'(n));
			per(1, 2 << n);
		end
		aux_run = 1'b1;
		wr(4'h6, 16'h0007);
		per(1, 10);
		per(3, 10);
		aux_run = 1'b0;
		wr(4'h6, 16'h0000);
	endtask
	task t_cc_lock;
		wr(4'h3, 16'h0001);
		per(0, 8);
		wr(4'h3, 16'h0002);
		per(0, 8);
		freeze_mode = 1'b1;
		wr(4'h3, 16'h0000);
		freeze_mode = 1'b0;
		per(0, 4);
	endtask
	task t_presc_rw;
		freeze_mode = 1'b1;
		wr(4'h8, 16'h0100);
		freeze_mode = 1'b0;
		rd(4'h8, d);
		rng(d, 16'h0100, 16'h0104);
		wr(4'h8, 16'h0000);
		rd(4'h8, d);
		rng(d, 16'h0104, 16'h010A);
	endtask
	task t_tbase;
		rd(4'h7, c1);
		cyc(20);
		rd(4'h7, d);
		rng(d, c1 + 16'h0004, c1 + 16'h0007);
		wr(4'h7, 16'h8000);
		rd(4'h7, d);
		rng(d, 16'h0000, 16'h7FFF);
		test_mode = 1'b1;
		wr(4'h7, 16'hFFF0);
		test_mode = 1'b0;
		rd(4'h7, d);
		rng(d, 16'hFFF0, 16'hFFF2);
		wr(4'h3, 16'h0080);
		wait_irq;
		rd(4'h4, d);
		chk(d & 16'h0080, 16'h0080);
		wr(4'h4, 16'h0000);
		rd(4'h4, d);
		chk(d & 16'h0080, 16'h0000);
		cyc(2);
		chk(16'(irq), 16'h0000);
		wr(4'h3, 16'h0000);
	endtask
	task t_capture;
		wr(4'h2, 16'h002D);
		wr(4'h3, 16'h0100);
		rd(4'h7, c1);
		ext_level = 8'h0F;
		cyc(8);
		rd(4'h4, d);
		chk(d & 16'h0F00, 16'h0300);
		chk(16'(irq), 16'h0001);
		rd(4'h9, d);
		rng(d, c1, c1 + 16'h0004);
		rd(4'hA, c1);
		chk(c1, d);
		rd(4'h4, d);
		wr(4'h4, 16'h0000);
		ext_level = 8'h00;
		cyc(8);
		rd(4'h4, d);
		chk(d & 16'h0F00, 16'h0600);
		chk(16'(irq), 16'h0000);
		rd(4'hA, c1);
		ext_level = 8'h0F;
		cyc(8);
		rd(4'hA, d);
		rng(d, c1 + 16'h0001, c1 + 16'h0010);
	endtask
	task t_flags;
		wr(4'h4, 16'h0000);
		rd(4'h4, d);
		chk(d & 16'h0F00, 16'h0300);
		wr(4'h4, 16'h0000);
		rd(4'h4, d);
		@(negedge clk);
		ext_level = 8'h00;
		#1 ext_level = 8'h0F;
		cyc(8);
		rd(4'h4, d);
		chk(d & 16'h0F00, 16'h0000);
		ext_level = 8'h00;
		cyc(3);
		ext_level = 8'h0F;
		cyc(8);
		rd(4'h4, d);
		chk(d & 16'h0F00, 16'h0700);
		wr(4'h4, 16'h0000);
	endtask
	task t_gpio;
		wr(4'h2, 16'h0001);
		ext_level = 8'h02;
		wr(4'h0, 16'h00F1);
		wr(4'h1, 16'h00A1);
		cyc(6);
		rd(4'h1, d);
		chk(d, 16'h00A3);
		rd(4'h4, d);
		chk(d & 16'h0F00, 16'h0100);
		oc_active = 5'h02;
		cyc(4);
		rd(4'h1, d);
		chk(d, 16'h0083);
		oc_level = 5'h02;
		wr(4'h1, 16'h0081);
		cyc(4);
		rd(4'h1, d);
		chk(d, 16'h00A3);
		oc_active = 5'h00;
		cyc(4);
		rd(4'h1, d);
		chk(d, 16'h0083);
	endtask
	task t_misc;
		acc_in = 1'b1;
		cyc(8);
		rd(4'h5, d);
		chk(d & 16'h00C0, 16'h0080);
		acc_in   = 1'b0;
		aux_rest = 1'b1;
		cyc(8);
		rd(4'h5, d);
		chk(d & 16'h00C0, 16'h0040);
		wr(4'h6, 16'h0330);
		cyc(2);
		chk({14'h0000, out_a, out_b}, 16'h0003);
		wr(4'h6, 16'h0300);
		cyc(2);
		chk({14'h0000, out_a, out_b}, 16'h0000);
		wave_a = 1'b1;
		wr(4'h6, 16'h0000);
		cyc(2);
		chk({14'h0000, out_a, out_b}, 16'h0002);
		wave_a = 1'b0;
		wr(4'h6, 16'h0008);
		per(5, 2);
		wr(4'h3, 16'h0020);
		per(4, 4);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		sys_rst     = 1'b1;
		test_mode   = 1'b0;
		freeze_mode = 1'b0;
		reg_rd      = 1'b0;
		reg_wr      = 1'b0;
		reg_addr    = 4'h0;
		reg_wdata   = 16'h0000;
		ext_level   = 8'h00;
		oc_active   = 5'h00;
		oc_level    = 5'h00;
		acc_in      = 1'b0;
		aux_run     = 1'b0;
		aux_rest    = 1'b0;
		wave_a      = 1'b0;
		wave_b      = 1'b0;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		t_reset;
		t_presc;
		t_cc_lock;
		t_presc_rw;
		t_tbase;
		t_capture;
		t_flags;
		t_gpio;
		t_misc;
		close_out;
	end
endmodule
